/* pdc_pkg.sv */
package pdc_pkg;

    // ********************************************************
    // Widths
    // ********************************************************
    localparam int PDC_NUM_WAKE_PINS = 8;   // Pin change wake sources
    localparam int PDC_NUM_KEEP      = 4;   // Retention RAM areas
    localparam int PDC_NUM_MODULES   = 8;   // Peripherals with stop bits

    // ********************************************************
    // Wake pin bit positions (c low..c high, g low, g high, j)
    // ********************************************************
    localparam int PDC_PIN_G_LOW  = 4;      // wake_pin_g_low position
    localparam int PDC_PIN_G_HIGH = 5;      // wake_pin_g_high position

    // Pins usable only on the large RAM variant
    localparam logic [7:0] PDC_PINS_LARGE_ONLY = 8'h30;
    // Keep bits present on every variant (areas 0 and 1)
    localparam logic [3:0] PDC_KEEP_ALWAYS     = 4'h3;

    // ********************************************************
    // Reset values
    // ********************************************************
    localparam logic [3:0] PDC_KEEP_RST    = 4'h0;  // No area kept
    localparam logic [3:0] PDC_HOLD_ALL    = 4'hF;  // All areas powered
    localparam logic [7:0] PDC_PINS_RST    = 8'h00; // No wake pin
    localparam logic [7:0] PDC_MOD_ALL_ON  = 8'hFF; // All modules clocked

    // ********************************************************
    // Power state, Gray coded along the deep standby entry and wake path
    // ********************************************************
    typedef enum logic [2:0] {
        PDC_ACTIVE = 3'h0,                  // Normal running
        PDC_ENTER  = 3'h1,                  // Sleep instruction executing
        PDC_DEEP   = 3'h3,                  // Deep standby, core unpowered
        PDC_WAKE   = 3'h2,                  // Power returning
        PDC_SLEEP  = 3'h6,                  // CPU halted
        PDC_SWSTBY = 3'h7                   // CPU and peripheral clocks stopped
    } pdc_mode_t;

    // Standby selection made by software before the sleep instruction
    typedef enum logic [1:0] {
        PDC_SEL_SLEEP  = 2'h0,
        PDC_SEL_SWSTBY = 2'h1,
        PDC_SEL_DEEP   = 2'h2
    } pdc_sel_t;

    // Recorded deep standby wake causes
    typedef struct packed {
        logic       por;                    // Power-on reset
        logic       nmi;                    // Non-maskable interrupt
        logic       alarm;                  // Clock alarm
        logic [7:0] pin;                    // Per wake pin change
    } pdc_flags_t;

    // Asynchronous events towards the controller
    typedef struct packed {
        logic nmi;                          // Non-maskable interrupt
        logic irq;                          // Maskable interrupt request
        logic manual_rst;                   // Manual reset
        logic por;                          // Power-on reset request
        logic alarm;                        // Clock alarm
    } pdc_events_t;

    // Power and clock enables
    typedef struct packed {
        logic cpu_clk_en;                   // CPU clock
        logic periph_clk_en;                // Peripheral clocks
        logic core_pwr_en;                  // Internal core supply
        logic rtc_clk_en;                   // Real-time clock
    } pdc_power_t;

endpackage : pdc_pkg

/* pdc_power_ctrl.sv */
module pdc_power_ctrl
    import pdc_pkg::*;
(
    input  wire logic        core_clk_i,        // 125 MHz clock
    input  wire logic        rst_n_i,           // Async reset, active low
    input  wire logic        large_ram_strap_i, // Large RAM variant strap
    input  wire logic        sleep_exec_i,      // Sleep instruction pulse
    input  wire pdc_sel_t    standby_sel_i,     // Mode chosen for sleep
    input  wire pdc_events_t events_i,          // Wake events
    input  wire logic [7:0]  wake_pins_i,       // Wake pin levels
    input  wire logic [7:0]  wake_pin_en_i,     // Wake pin enables
    input  wire logic [3:0]  keep_bits_i,       // retention_keep_control
    input  wire logic        pins_hiz_sel_i,    // 1: pins high-Z in deep
    input  wire logic        rtc_run_i,         // Clock run bit
    input  wire logic        fast_ram_enable_i, // fast_ram_enable
    input  wire logic        fast_ram_write_enable_i, // Write enable
    input  wire logic        large_ram_enable_i,      // large_ram_enable
    input  wire logic        large_ram_write_enable_i, // Write enable
    input  wire logic [7:0]  module_stop_bit_i, // 1: module stopped
    input  wire logic        pin_hold_clear_i,  // Pin hold bit cleared
    input  wire logic        flag_clear_i,      // Clear wake flags
    output pdc_mode_t        mode_o,            // Current power state
    output pdc_power_t       power_o,           // Clock and power enables
    output logic [3:0]       ret_hold_o,        // Retention area powered
    output logic             ret_init_o,        // Init retention RAM pulse
    output logic             fast_ram_init_o,   // Init fast RAM pulse
    output logic             large_ram_init_o,  // Init large RAM pulse
    output logic             reset_exc_o,       // Reset exception pulse
    output logic             int_accept_o,      // Entry aborted pulse
    output logic             rtc_lost_o,        // Clock control lost
    output logic [7:0]       module_clk_en_o,   // Per module clock
    output logic             pin_hold_o,        // Pins frozen
    output logic             pins_hiz_o,        // Pins high-Z
    output pdc_flags_t       deep_standby_flag_reg_o // Wake causes
);

    // ********************************************************
    // State record
    // ********************************************************
    typedef struct packed {
        pdc_mode_t  mode;                   // Power state
        pdc_sel_t   target;                 // Mode latched at entry
        logic       variant;                // Large RAM variant
        logic       strap_done;             // Strap captured
        logic [3:0] keep;                   // Keep bits latched at entry
        logic [7:0] pin_en;                 // Wake pins latched at entry
        logic [7:0] pin_snap;               // Pin levels at entry
        logic       hiz_sel;                // Pin choice at entry
        pdc_power_t power;                  // Enables
        logic [3:0] ret_hold;               // Retention power
        logic       ret_init;               // Pulses
        logic       fast_init;
        logic       large_init;
        logic       reset_exc;
        logic       int_accept;
        logic       rtc_lost;               // Level, set by deep wake
        logic [7:0] mod_clk_en;             // Module clocks
        logic       pin_hold;               // Pin freeze
        logic       pins_hiz;               // Pin high-Z
        pdc_flags_t flags;                  // Wake causes
    } pdc_state_t;
    pdc_state_t st_reg;                     // Registered state
    pdc_state_t st_next;                    // Next state
    logic [7:0] pin_change;                 // Enabled pins that moved
    logic       deep_wake;                  // Any deep exit cause
    logic       abort_req;                  // Entry interrupted
    // Reset value of the whole record
    function automatic pdc_state_t pdc_rst_val();
        pdc_state_t s;
        s            = '0;                  // Idle and sleep choice are zero
        s.keep       = PDC_KEEP_RST;
        s.pin_en     = PDC_PINS_RST;
        s.power      = '{1'b1, 1'b1, 1'b1, 1'b0};
        s.ret_hold   = PDC_HOLD_ALL;
        s.mod_clk_en = PDC_MOD_ALL_ON;
        return s;
    endfunction : pdc_rst_val
    // Enables per state; the clock follows its run bit everywhere
    function automatic pdc_power_t pdc_power_of(input pdc_mode_t m,
                                                input logic      run);
        pdc_power_t p;
        p = '{1'b1, 1'b1, 1'b1, run};
        case (m)
            PDC_SLEEP:  p.cpu_clk_en = 1'b0;
            PDC_SWSTBY: {p.cpu_clk_en, p.periph_clk_en} = 2'h0;
            PDC_DEEP:   {p.cpu_clk_en, p.periph_clk_en,
                         p.core_pwr_en} = 3'h0;
            default: ;
        endcase
        return p;
    endfunction : pdc_power_of
    // ********************************************************
    // Wake decoding
    // ********************************************************
    // Level change on an enabled pin since the entry snapshot
    assign pin_change = (wake_pins_i ^ st_reg.pin_snap) & st_reg.pin_en;
    assign deep_wake  = events_i.nmi | events_i.alarm | events_i.por
                      | (|pin_change);
    // Only interrupts and manual reset race the sleep instruction
    assign abort_req  = events_i.nmi | events_i.irq | events_i.manual_rst;

    // ********************************************************
    // Next state
    // ********************************************************
    always_comb begin
        st_next            = st_reg;
        st_next.ret_init   = 1'b0;
        st_next.fast_init  = 1'b0;
        st_next.large_init = 1'b0;
        st_next.reset_exc  = 1'b0;
        st_next.int_accept = 1'b0;
        // Strap taken once, the first edge after reset release
        if (!st_reg.strap_done) begin
            st_next.variant    = large_ram_strap_i;
            st_next.strap_done = 1'b1;
        end
        // Software clear of the flags; a new cause below wins
        if (flag_clear_i) begin
            st_next.flags = '0;
        end
        if (pin_hold_clear_i) begin
            st_next.pin_hold = 1'b0;
            st_next.rtc_lost = 1'b0;
        end
        case (st_reg.mode)
            PDC_ACTIVE: begin
                // Only the sleep instruction starts any standby
                if (sleep_exec_i) begin
                    st_next.mode    = PDC_ENTER;
                    st_next.target  = standby_sel_i;
                    // Upper keep bits ignored on the small variant
                    st_next.keep    = keep_bits_i &
                        (st_reg.variant ? PDC_HOLD_ALL
                                        : PDC_KEEP_ALWAYS);
                    // Two g pins wake only on the large variant
                    st_next.pin_en  = wake_pin_en_i &
                        (st_reg.variant ? 8'hFF
                                        : ~PDC_PINS_LARGE_ONLY);
                    st_next.pin_snap = wake_pins_i;
                    st_next.hiz_sel  = pins_hiz_sel_i;
                end
            end
            PDC_ENTER: begin
                // Racing interrupt is accepted, entry abandoned
                if (abort_req) begin
                    st_next.mode       = PDC_ACTIVE;
                    st_next.int_accept = 1'b1;
                end else begin
                    case (st_reg.target)
                        PDC_SEL_SWSTBY: st_next.mode = PDC_SWSTBY;
                        PDC_SEL_DEEP: begin
                            st_next.mode     = PDC_DEEP;
                            st_next.pin_hold = 1'b1;
                            st_next.pins_hiz = st_reg.hiz_sel;
                            st_next.ret_hold = st_reg.keep;
                        end
                        default:        st_next.mode = PDC_SLEEP;
                    endcase
                end
            end
            PDC_SLEEP: begin
                if (abort_req | events_i.por) begin
                    st_next.mode = PDC_ACTIVE;
                end
            end
            PDC_SWSTBY: begin
                if (events_i.por) begin
                    st_next.mode       = PDC_ACTIVE;
                    // Software keeps data by clearing an enable
                    st_next.fast_init  = fast_ram_enable_i &
                                         fast_ram_write_enable_i;
                    st_next.large_init = large_ram_enable_i &
                                         large_ram_write_enable_i;
                end else if (events_i.nmi | events_i.irq) begin
                    st_next.mode = PDC_ACTIVE;
                end
            end
            PDC_DEEP: begin
                if (deep_wake) begin
                    st_next.mode      = PDC_WAKE;
                    st_next.reset_exc = 1'b1;
                    st_next.ret_init  = events_i.por;
                    st_next.rtc_lost  = 1'b1;
                    st_next.pins_hiz  = 1'b0;
                    st_next.ret_hold  = PDC_HOLD_ALL;
                    // Builds on the cleared copy so that a set wins
                    st_next.flags = st_next.flags | {events_i.por,
                        events_i.nmi, events_i.alarm, pin_change};
                end
            end
            PDC_WAKE: st_next.mode = PDC_ACTIVE; // Supply settles
            default:  st_next.mode = PDC_ACTIVE;
        endcase
        st_next.power = pdc_power_of(st_next.mode, rtc_run_i);
        // Power-on reset request clocks every module for one cycle; manual reset does not
        st_next.mod_clk_en = events_i.por ? PDC_MOD_ALL_ON
                                          : ~module_stop_bit_i;
    end

    // ********************************************************
    // State register
    // ********************************************************
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_reg <= pdc_rst_val();
        end else begin
            st_reg <= st_next;
        end
    end

    // Every output is a field of the state register
    assign mode_o                  = st_reg.mode;
    assign power_o                 = st_reg.power;
    assign ret_hold_o              = st_reg.ret_hold;
    assign ret_init_o              = st_reg.ret_init;
    assign fast_ram_init_o         = st_reg.fast_init;
    assign large_ram_init_o        = st_reg.large_init;
    assign reset_exc_o             = st_reg.reset_exc;
    assign int_accept_o            = st_reg.int_accept;
    assign rtc_lost_o              = st_reg.rtc_lost;
    assign module_clk_en_o         = st_reg.mod_clk_en;
    assign pin_hold_o              = st_reg.pin_hold;
    assign pins_hiz_o              = st_reg.pins_hiz;
    assign deep_standby_flag_reg_o = st_reg.flags;

    // ********************************************************
    // Checks
    // ********************************************************
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_deep_exit;
        st_reg.mode == PDC_DEEP && deep_wake;
    endsequence
    sequence s_entering;
        st_reg.mode == PDC_ENTER;
    endsequence
    property p_deep_power;
        mode_o == PDC_DEEP |-> !power_o.core_pwr_en && !power_o.cpu_clk_en;
    endproperty
    a_deep_power: assert property (p_deep_power)
        else $error("Core powered in deep standby");
    property p_deep_exit;
        s_deep_exit |=> mode_o == PDC_WAKE ##1 mode_o == PDC_ACTIVE;
    endproperty
    a_deep_exit: assert property (p_deep_exit)
        else $error("Deep standby not left on wake cause");
    property p_reset_exc;
        s_deep_exit |=> reset_exc_o ##1 !reset_exc_o;
    endproperty
    a_reset_exc: assert property (p_reset_exc)
        else $error("No reset exception after deep wake");
    property p_small_pins;
        st_reg.strap_done && !st_reg.variant
            |-> (st_reg.pin_en & PDC_PINS_LARGE_ONLY) == 8'h00;
    endproperty
    a_small_pins: assert property (p_small_pins)
        else $error("Large-only wake pin enabled");
    // Starts once the first edge after release has been registered
    property p_rtc_run;
        st_reg.strap_done |-> power_o.rtc_clk_en == $past(rtc_run_i);
    endproperty
    a_rtc_run: assert property (p_rtc_run)
        else $error("Clock enable ignores run bit");
    property p_keep;
        mode_o == PDC_DEEP |-> ret_hold_o == st_reg.keep;
    endproperty
    a_keep: assert property (p_keep)
        else $error("Retention area power wrong in deep");
    property p_deep_por;
        s_deep_exit ##0 events_i.por
            |=> ret_init_o && deep_standby_flag_reg_o.por;
    endproperty
    a_deep_por: assert property (p_deep_por)
        else $error("Retention RAM not initialised on reset");
    property p_small_keep;
        !st_reg.variant |-> st_reg.keep[3:2] == 2'h0;
    endproperty
    a_small_keep: assert property (p_small_keep)
        else $error("Upper keep bit on small variant");
    property p_sw_por;
        st_reg.mode == PDC_SWSTBY && events_i.por
            |=> fast_ram_init_o == $past(fast_ram_enable_i &
                                         fast_ram_write_enable_i);
    endproperty
    a_sw_por: assert property (p_sw_por)
        else $error("Fast RAM init wrong on standby reset");
    property p_module;
        st_reg.strap_done |-> module_clk_en_o == ($past(events_i.por)
                               ? 8'hFF : ~$past(module_stop_bit_i));
    endproperty
    a_module: assert property (p_module)
        else $error("Module clock does not follow stop bit");
    property p_abort;
        s_entering ##0 abort_req |=> mode_o == PDC_ACTIVE && int_accept_o;
    endproperty
    a_abort: assert property (p_abort)
        else $error("Racing interrupt not accepted");
    property p_hold;
        pin_hold_o && !pin_hold_clear_i |=> pin_hold_o;
    endproperty
    a_hold: assert property (p_hold)
        else $error("Pin hold released without clear");
    property p_entry;
        st_reg.mode == PDC_ACTIVE && !sleep_exec_i |=> mode_o == PDC_ACTIVE;
    endproperty
    a_entry: assert property (p_entry)
        else $error("Standby entered without sleep");
    property p_flag;
        s_deep_exit ##0 events_i.alarm |=> deep_standby_flag_reg_o.alarm;
    endproperty
    a_flag: assert property (p_flag)
        else $error("Alarm wake not recorded");

endmodule : pdc_power_ctrl

/* pdc_cpu_model.sv */
module pdc_cpu_model
    import pdc_pkg::*;
(
    input  wire logic   clk_i,      // Core clock
    output logic        sleep_o,    // Sleep instruction pulse
    output pdc_sel_t    sel_o,      // Standby choice
    output pdc_events_t ev_o,       // Wake and abort events
    output logic [7:0]  pins_o,     // Wake pin levels
    output logic [7:0]  pin_en_o,   // Wake pin enables
    output logic [3:0]  keep_o,     // Retention keep bits
    output logic        hiz_o,      // High-Z choice for deep standby
    output logic        rtc_run_o,  // Clock run bit
    output logic [3:0]  ram_en_o,   // Fast en, fast we, large en, large we
    output logic [7:0]  stop_o,     // Module stop bits
    output logic        hold_clr_o, // Pin hold clear
    output logic        flag_clr_o  // Wake flag clear
);
    timeunit 1ns;
    timeprecision 1ps;
    // ********************************************************
    // Software steps, each launched on a rising edge
    // ********************************************************
    initial begin // Idle CPU with the clock running
        {sleep_o, hiz_o, hold_clr_o, flag_clr_o} = 4'h0;
        {pins_o, pin_en_o, stop_o} = 24'h000000;
        {keep_o, ram_en_o} = 8'h00;
        ev_o = '0;
        sel_o = PDC_SEL_SLEEP;
        rtc_run_o = 1'b1;
    end
    // Configure before entry; the spare cycle stands in for the dummy read
    task automatic setup(input logic [3:0] k, input logic h,
                         input logic [7:0] en);
        @(posedge clk_i);
        keep_o    <= k;
        hiz_o     <= h;
        pin_en_o  <= en;
        rtc_run_o <= 1'b1;
        @(posedge clk_i);
    endtask : setup
    // RAM enables chosen so that only one region is reinitialised
    task automatic set_misc(input logic [3:0] ram, input logic [7:0] stp,
                            input logic run);
        @(posedge clk_i);
        ram_en_o  <= ram;
        stop_o    <= stp;
        rtc_run_o <= run;
        @(posedge clk_i);
    endtask : set_misc
    // Sleep instruction; ab arrives while the instruction executes
    task automatic enter_sleep(input pdc_sel_t s, input pdc_events_t ab);
        @(posedge clk_i);
        sleep_o <= 1'b1;
        sel_o   <= s;
        @(posedge clk_i);
        sleep_o <= 1'b0;
        ev_o    <= ab;
        @(posedge clk_i);
        ev_o    <= '0;
    endtask : enter_sleep
    // One cycle event together with new pin levels
    task automatic event_in(input pdc_events_t e, input logic [7:0] p);
        @(posedge clk_i);
        ev_o   <= e;
        pins_o <= p;
        @(posedge clk_i);
        ev_o   <= '0;
    endtask : event_in
    // Clock control is lost in deep standby, so it is set up again
    task automatic restore();
        @(posedge clk_i);
        rtc_run_o  <= 1'b1;
        hold_clr_o <= 1'b1;
        flag_clr_o <= 1'b1;
        @(posedge clk_i);
        {hold_clr_o, flag_clr_o} <= 2'h0;
    endtask : restore
endmodule : pdc_cpu_model

/* pdc_power_ctrl_tb_top.sv */
module pdc_power_ctrl_tb_top
    import pdc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ********************************************************
    // Signals
    // ********************************************************
    logic        clk = 1'b0, rst_n = 1'b0, strap = 1'b0; // Clock, reset
    logic        slp, hiz, run, hclr, fclr;              // Partner drives
    pdc_sel_t    sel;                                    // Standby choice
    pdc_events_t ev;                                     // Events
    logic [7:0]  pins, pen, stp, mclk;                   // Pins, modules
    logic [3:0]  keep, ram, hold;                        // Keep, RAM, hold
    pdc_mode_t   mode;                                   // Power state
    pdc_power_t  pwr;                                    // Enables
    pdc_flags_t  flags;                                  // Wake causes
    logic        rinit, finit, linit, rexc, iacc, lost, phold, phiz;
    int          num_errors = 0, checks_done = 0, cycles = 0;
    logic [4:0]  ev_tab [4] = '{5'h01, 5'h10, 5'h02, 5'h00};
    logic [10:0] fl_tab [4] = '{11'h100, 11'h200, 11'h400, 11'h001};
    logic [7:0]  pn_tab [4] = '{8'h30, 8'h30, 8'h30, 8'h31};
    always #4 clk = ~clk; // 125 MHz
    pdc_cpu_model u_cpu (.clk_i(clk), .sleep_o(slp), .sel_o(sel),
        .ev_o(ev), .pins_o(pins), .pin_en_o(pen), .keep_o(keep),
        .hiz_o(hiz), .rtc_run_o(run), .ram_en_o(ram), .stop_o(stp),
        .hold_clr_o(hclr), .flag_clr_o(fclr));
    pdc_power_ctrl DUT (.core_clk_i(clk), .rst_n_i(rst_n),
        .large_ram_strap_i(strap), .sleep_exec_i(slp), .standby_sel_i(sel),
        .events_i(ev), .wake_pins_i(pins), .wake_pin_en_i(pen),
        .keep_bits_i(keep), .pins_hiz_sel_i(hiz), .rtc_run_i(run),
        .fast_ram_enable_i(ram[3]), .fast_ram_write_enable_i(ram[2]),
        .large_ram_enable_i(ram[1]), .large_ram_write_enable_i(ram[0]),
        .module_stop_bit_i(stp), .pin_hold_clear_i(hclr),
        .flag_clear_i(fclr), .mode_o(mode),
        .power_o(pwr), .ret_hold_o(hold), .ret_init_o(rinit),
        .fast_ram_init_o(finit), .large_ram_init_o(linit),
        .reset_exc_o(rexc), .int_accept_o(iacc), .rtc_lost_o(lost),
        .module_clk_en_o(mclk), .pin_hold_o(phold), .pins_hiz_o(phiz),
        .deep_standby_flag_reg_o(flags));
    // ********************************************************
    // Checking and closing
    // ********************************************************
    task automatic chk(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic stop_test();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : stop_test
    // A hang is cut short well above the fewer than one hundred cycles needed
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            stop_test();
        end
    end
    // ********************************************************
    // Scenarios
    // ********************************************************
    initial begin
        repeat (5) @(posedge clk);
        #1 chk("rst mode", mode, PDC_ACTIVE);
        chk("rst power", pwr, 4'hE);
        chk("rst hold", hold, PDC_HOLD_ALL);
        chk("rst mclk", mclk, PDC_MOD_ALL_ON);
        chk("rst flags", flags, 11'h000);
        @(posedge clk) rst_n <= 1'b1;
        // Deep standby left by alarm, NMI, reset and a pin change
        for (int i = 0; i < 4; i++) begin
            u_cpu.setup(4'hF, i[0], 8'h31);
            u_cpu.enter_sleep(PDC_SEL_DEEP, '0);
            #1 chk("deep mode", mode, PDC_DEEP);
            chk("core pwr", pwr.core_pwr_en, 1'b0);
            chk("keep", hold, 4'h3);
            chk("hiz", phiz, i[0]);
            u_cpu.event_in(5'h08, 8'h30);
            #1 chk("ignore", mode, PDC_DEEP);
            u_cpu.event_in(ev_tab[i], pn_tab[i]);
            #1 chk("wake mode", mode, PDC_WAKE);
            chk("rst exc", rexc, 1'b1);
            chk("flags", flags, fl_tab[i]);
            chk("ret init", rinit, i == 2);
            chk("rtc lost", lost, 1'b1);
            @(posedge clk);
            #1 chk("back", mode, PDC_ACTIVE);
            chk("frozen", phold, 1'b1);
            u_cpu.restore();
            #1 chk("unfrozen", phold, 1'b0);
            chk("flag clr", flags, 11'h000);
        end
        // Software standby with stopped modules, left by reset
        u_cpu.set_misc(4'hD, 8'h0F, 1'b1);
        u_cpu.enter_sleep(PDC_SEL_SWSTBY, '0);
        #1 chk("sw mode", mode, PDC_SWSTBY);
        chk("rtc on", pwr.rtc_clk_en, 1'b1);
        chk("mstop", mclk, 8'hF0);
        u_cpu.event_in(5'h04, 8'h31);
        #1 chk("sw ignore", mode, PDC_SWSTBY);
        u_cpu.event_in(5'h02, 8'h31);
        #1 chk("sw exit", mode, PDC_ACTIVE);
        chk("fast init", finit, 1'b1);
        chk("large init", linit, 1'b0);
        chk("por mclk", mclk, 8'hFF);
        // Sleep with the clock stopped, then an aborted entry
        u_cpu.set_misc(4'h0, 8'h00, 1'b0);
        u_cpu.enter_sleep(PDC_SEL_SLEEP, '0);
        #1 chk("sleep", mode, PDC_SLEEP);
        chk("rtc off", pwr.rtc_clk_en, 1'b0);
        u_cpu.event_in(5'h08, 8'h31);
        #1 chk("irq wake", mode, PDC_ACTIVE);
        u_cpu.enter_sleep(PDC_SEL_DEEP, 5'h10);
        #1 chk("abort", iacc, 1'b1);
        chk("abort mode", mode, PDC_ACTIVE);
        // Reset in mid-run as the large variant: upper keep bits, g pins
        @(posedge clk) rst_n <= 1'b0;
        strap <= 1'b1;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        u_cpu.setup(4'hF, 1'b0, 8'h31);
        u_cpu.enter_sleep(PDC_SEL_DEEP, '0);
        #1 chk("big keep", hold, 4'hF);
        u_cpu.event_in(5'h00, 8'h21);
        #1 chk("g pin wake", mode, PDC_WAKE);
        chk("g pin flag", flags, 11'h010);
        stop_test();
    end
endmodule : pdc_power_ctrl_tb_top
